// ---- core/pmrar_pkg.sv ----
package pmrar_pkg;

  // ***********************************************
  // address space
  // ***********************************************
  localparam int unsigned IDX_W = 10;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SPACE_SIZE = 1024;
  localparam logic [15:0] UC_BASE = 16'hA000;
  localparam logic [15:0] UC_SPAN = 16'h0400;
  localparam logic [7:0] GLOBAL_LOW = 8'h10;

  // ***********************************************
  // region bases (index) and sizes (bytes)
  // ***********************************************
  localparam logic [9:0] GLB_BASE = 10'h000;
  localparam logic [9:0] ACC_BASE = 10'h010;
  localparam logic [9:0] PWR_BASE = 10'h020;
  localparam logic [9:0] RTC_BASE = 10'h040;
  localparam logic [9:0] LDO_BASE = 10'h060;
  localparam logic [9:0] SWR_BASE = 10'h080;
  localparam logic [9:0] CHG_BASE = 10'h090;
  localparam logic [9:0] TMR_BASE = 10'h0A0;
  localparam logic [9:0] RSV0_BASE = 10'h0B0;
  localparam logic [9:0] TCH_BASE = 10'h0C0;
  localparam logic [9:0] AUD_BASE = 10'h100;
  localparam logic [9:0] SPK_BASE = 10'h200;
  localparam logic [9:0] RSV3_BASE = 10'h300;
  localparam logic [9:0] SZ16 = 10'h010;
  localparam logic [9:0] SZ32 = 10'h020;
  localparam logic [9:0] SZ64 = 10'h040;
  localparam logic [9:0] SZ240 = 10'h0F0;

  // ***********************************************
  // global register offsets and reset values
  // ***********************************************
  localparam logic [3:0] GR_PAGE = 4'h0;
  localparam logic [3:0] GR_ROUTE0 = 4'h1;
  localparam logic [3:0] GR_ROUTE1 = 4'h2;
  localparam logic [3:0] GR_STAT0 = 4'h3;
  localparam logic [3:0] GR_STAT1 = 4'h4;
  localparam logic [3:0] GR_ACTION = 4'h5;
  localparam logic [3:0] GR_STATE = 4'h6;
  localparam logic [1:0] PAGE_RST = 2'h0;
  localparam logic [15:0] ROUTE_RST = 16'h0000;
  localparam logic [15:0] STAT_RST = 16'h0000;
  localparam logic [7:0] ACTION_RST = 8'h00;

  // ***********************************************
  // types
  // ***********************************************
  typedef enum logic [3:0] {
    RG_GLOBAL = 4'b0000,
    RG_ACCESS = 4'b0001,
    RG_POWER = 4'b0010,
    RG_RTC = 4'b0011,
    RG_LDO = 4'b0100,
    RG_SWREG = 4'b0101,
    RG_CHARGER = 4'b0110,
    RG_TIMERS = 4'b0111,
    RG_TOUCH = 4'b1000,
    RG_AUDIO = 4'b1001,
    RG_SPKAMP = 4'b1010,
    RG_NONE = 4'b1111
  } pmrar_region_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DEC = 2'b01,
    ST_MOD = 2'b10
  } pmrar_state_t;

  typedef struct packed {
    logic we;
    logic [9:0] idx;
    logic [7:0] wdata;
  } pmrar_acc_t;

  typedef struct packed {
    logic req;
    logic we;
    pmrar_region_t region;
    logic [7:0] off;
    logic [7:0] wdata;
  } pmrar_mod_req_t;

endpackage

// ---- core/pmrar_region_dec.sv ----
`timescale 1ns/1ps

module pmrar_region_dec (
  // flat register index
  input wire logic [9:0] idx,
  // selected region and offset inside it
  output pmrar_pkg::pmrar_region_t region,
  output logic [7:0] off
);

  // true when idx lies in [base, base+size)
  function automatic logic in_rng(input logic [9:0] a,
                                  input logic [9:0] base,
                                  input logic [9:0] size);
    logic [9:0] d;
    d = a - base;
    in_rng = (a >= base) && (d < size);
  endfunction

  // [RQ5] one region per address
  // priority chain gives exactly one hit; holes fall to none
  always_comb begin
    region = pmrar_pkg::RG_NONE;
    off = 8'h00;
    if (in_rng(idx, pmrar_pkg::GLB_BASE, pmrar_pkg::SZ16)) begin
      region = pmrar_pkg::RG_GLOBAL;
      off = 8'(idx - pmrar_pkg::GLB_BASE);
    end else if (in_rng(idx, pmrar_pkg::ACC_BASE, pmrar_pkg::SZ16)) begin
      region = pmrar_pkg::RG_ACCESS;
      off = 8'(idx - pmrar_pkg::ACC_BASE);
    end else if (in_rng(idx, pmrar_pkg::PWR_BASE, pmrar_pkg::SZ32)) begin
      region = pmrar_pkg::RG_POWER;
      off = 8'(idx - pmrar_pkg::PWR_BASE);
    end else if (in_rng(idx, pmrar_pkg::RTC_BASE, pmrar_pkg::SZ32)) begin
      region = pmrar_pkg::RG_RTC;
      off = 8'(idx - pmrar_pkg::RTC_BASE);
    end else if (in_rng(idx, pmrar_pkg::LDO_BASE, pmrar_pkg::SZ32)) begin
      region = pmrar_pkg::RG_LDO;
      off = 8'(idx - pmrar_pkg::LDO_BASE);
    end else if (in_rng(idx, pmrar_pkg::SWR_BASE, pmrar_pkg::SZ16)) begin
      region = pmrar_pkg::RG_SWREG;
      off = 8'(idx - pmrar_pkg::SWR_BASE);
    end else if (in_rng(idx, pmrar_pkg::CHG_BASE, pmrar_pkg::SZ16)) begin
      region = pmrar_pkg::RG_CHARGER;
      off = 8'(idx - pmrar_pkg::CHG_BASE);
    end else if (in_rng(idx, pmrar_pkg::TMR_BASE, pmrar_pkg::SZ16)) begin
      region = pmrar_pkg::RG_TIMERS;
      off = 8'(idx - pmrar_pkg::TMR_BASE);
    end else if (in_rng(idx, pmrar_pkg::TCH_BASE, pmrar_pkg::SZ64)) begin
      region = pmrar_pkg::RG_TOUCH;
      off = 8'(idx - pmrar_pkg::TCH_BASE);
    end else if (in_rng(idx, pmrar_pkg::AUD_BASE, pmrar_pkg::SZ240)) begin
      region = pmrar_pkg::RG_AUDIO;
      off = 8'(idx - pmrar_pkg::AUD_BASE);
    end else if (in_rng(idx, pmrar_pkg::SPK_BASE, pmrar_pkg::SZ240)) begin
      region = pmrar_pkg::RG_SPKAMP;
      off = 8'(idx - pmrar_pkg::SPK_BASE);
    end
  end

endmodule // pmrar_region_dec

// ---- core/pmrar_router.sv ----
`timescale 1ns/1ps
// Behaviour
// [RQ1] all registers live in one 1024-byte space, flat for the micro
// [RQ2] i2c side sees four 256-byte pages: page select plus byte address
// [RQ3] in-page addresses below 0x10 always reach the global registers
// [RQ4] register address is module base plus offset, on both sides
// [RQ5] each module owns one contiguous region, one region per address
// [RQ6] hardware arbiter serialises external and micro accesses
// [RQ7] both masters reach every register while the micro runs; i2c side cannot reach audio and speaker offsets 0x00-0x0F
// [RQ8] micro may be off or unclocked; i2c access stays complete
// [RQ9] interrupts for the external processor leave on a pin
// [RQ10] each interrupt source routes to micro or to the pin
// [RQ11] micro runs its program while external accesses still proceed
// [RQ12] global region: 16 bytes at 0xA000 and in-page 0x00
// [RQ13] access manager region: 16 bytes at page 0 offset 0x10
// [RQ14] power controller 32 bytes at 0x20, clock 32 bytes at 0x40
// [RQ15] linear regulators 32 bytes at page 0 offset 0x60
// [RQ16] switching regulators 16 bytes at page 0 offset 0x80
// [RQ17] charger at 0xA090, timers at 0xA0A0, 0xA0B0 reserved
// [RQ18] touch, adc and gpio 64 bytes at page 0 offset 0xC0
// [RQ19] audio 240 bytes from page 1 offset 0x00
// [RQ20] speaker amp digital 240 bytes on page 2; page 3 reserved
// [RQ21] registers are bytes; multi-byte ones use consecutive addresses
// [RQ22] writing one clears a status bit, zero leaves it
// [RQ23] writing one to an action bit fires it; bit stays readable
// [RQ24] software read-modify-writes and skips all-reserved registers
// [RQ25] fixed priority, grant held until the byte access ends
// [RQ26] reserved reads give zero, reserved writes do nothing

module pmrar_router #(
  parameter int unsigned N_IRQ = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // external processor byte port, behind the i2c slave
  input wire logic ext_req,
  input wire logic ext_we,
  input wire logic [7:0] ext_addr,
  input wire logic [7:0] ext_wdata,
  output logic ext_ack_q,
  output logic [7:0] ext_rdata_q,
  // on-chip micro local bus
  input wire logic uc_run,
  input wire logic uc_req,
  input wire logic uc_we,
  input wire logic [15:0] uc_addr,
  input wire logic [7:0] uc_wdata,
  output logic uc_ack_q,
  output logic [7:0] uc_rdata_q,
  // downstream module port
  output pmrar_pkg::pmrar_mod_req_t mod_req_q,
  input wire logic mod_ack,
  input wire logic [7:0] mod_rdata,
  // interrupt sources and targets
  input wire logic [N_IRQ-1:0] irq_event,
  output logic irq_ext_q,
  output logic irq_uc_q,
  // action strobe
  output logic action_pulse_q,
  // current page
  output logic [1:0] page_q
);

  // ***********************************************
  // declarations
  // ***********************************************
  pmrar_pkg::pmrar_state_t st_q;
  pmrar_pkg::pmrar_acc_t acc_q;
  pmrar_pkg::pmrar_acc_t ext_acc;
  pmrar_pkg::pmrar_acc_t uc_acc;
  pmrar_pkg::pmrar_region_t region;
  logic [7:0] off;
  logic owner_ext_q;
  logic [15:0] uc_rel;
  logic uc_in_space;
  logic uc_take;
  logic ext_take;
  logic ans_now;
  logic [7:0] ans_data;
  logic [7:0] glb_rdata;
  logic glb_wr;
  logic is_local;
  logic [15:0] route_q;
  logic [15:0] stat_q;
  logic [15:0] stat_d;
  logic [15:0] stat_clr;
  logic [15:0] ev_wide;
  logic [7:0] action_q;

  // ***********************************************
  // external address forming
  // ***********************************************

  // [RQ2] page select joins the in-page byte
  // [RQ3] low 16 in-page bytes redirect to global
  always_comb begin
    ext_acc.we = ext_we;
    ext_acc.wdata = ext_wdata;
    if (ext_addr < pmrar_pkg::GLOBAL_LOW) begin
      ext_acc.idx = {2'b00, ext_addr};
    end else begin
      ext_acc.idx = {page_q, ext_addr};
    end
  end

  // ***********************************************
  // micro address forming
  // ***********************************************

  // [RQ1] flat window of 1024 bytes from 0xA000
  // [RQ12] global bytes start at the window base
  assign uc_rel = uc_addr - pmrar_pkg::UC_BASE;
  assign uc_in_space = (uc_addr >= pmrar_pkg::UC_BASE) &&
                       (uc_rel < pmrar_pkg::UC_SPAN);

  // outside the window the access is answered as reserved
  always_comb begin
    uc_acc.we = uc_we & uc_in_space;
    uc_acc.wdata = uc_wdata;
    if (uc_in_space) begin
      uc_acc.idx = uc_rel[9:0];
    end else begin
      uc_acc.idx = pmrar_pkg::RSV3_BASE;
    end
  end

  // ***********************************************
  // region decode
  // ***********************************************

  // [RQ4] offset is index less module base
  // [RQ13] [RQ14] [RQ15] [RQ16] region bases in decoder
  // [RQ17] [RQ18] [RQ19] [RQ20] further bases in decoder
  pmrar_region_dec u_dec (
    .idx(acc_q.idx),
    .region(region),
    .off(off)
  );

  assign is_local = (region == pmrar_pkg::RG_GLOBAL) ||
                    (region == pmrar_pkg::RG_NONE);

  // ***********************************************
  // arbitration
  // ***********************************************

  // [RQ6] [RQ25] external first, micro waits
  // a master whose answer is on the port is not retaken
  // [RQ8] a stopped micro cannot hold the arbiter
  assign ext_take = ext_req && !ext_ack_q;
  assign uc_take = uc_req && uc_run && !uc_ack_q && !ext_take;

  // [RQ7] [RQ11] both masters share the same path
  // [RQ25] grant held until answer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= pmrar_pkg::ST_IDLE;
      owner_ext_q <= 1'b0;
      acc_q <= '0;
    end else begin
      case (st_q)
        pmrar_pkg::ST_IDLE: begin
          if (ext_take) begin
            owner_ext_q <= 1'b1;
            acc_q <= ext_acc;
            st_q <= pmrar_pkg::ST_DEC;
          end else if (uc_take) begin
            owner_ext_q <= 1'b0;
            acc_q <= uc_acc;
            st_q <= pmrar_pkg::ST_DEC;
          end
        end
        pmrar_pkg::ST_DEC: begin
          if (is_local) begin
            st_q <= pmrar_pkg::ST_IDLE;
          end else begin
            st_q <= pmrar_pkg::ST_MOD;
          end
        end
        pmrar_pkg::ST_MOD: begin
          if (mod_ack) begin
            st_q <= pmrar_pkg::ST_IDLE;
          end
        end
        default: begin
          st_q <= pmrar_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ***********************************************
  // downstream module port
  // ***********************************************

  // [RQ21] one byte per access, offset passed on
  // request stands until the module acknowledges
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mod_req_q <= '0;
    end else if (st_q == pmrar_pkg::ST_DEC && !is_local) begin
      mod_req_q.req <= 1'b1;
      mod_req_q.we <= acc_q.we;
      mod_req_q.region <= region;
      mod_req_q.off <= off;
      mod_req_q.wdata <= acc_q.wdata;
    end else if (st_q == pmrar_pkg::ST_MOD && mod_ack) begin
      mod_req_q.req <= 1'b0;
    end
  end

  // ***********************************************
  // answer to the granted master
  // ***********************************************

  assign ans_now = (st_q == pmrar_pkg::ST_DEC && is_local) ||
                   (st_q == pmrar_pkg::ST_MOD && mod_ack);

  // [RQ26] unmapped bytes read back zero
  always_comb begin
    if (st_q == pmrar_pkg::ST_MOD) begin
      ans_data = mod_rdata;
    end else if (region == pmrar_pkg::RG_GLOBAL) begin
      ans_data = glb_rdata;
    end else begin
      ans_data = 8'h00;
    end
  end

  // one-cycle ack with data to the owner only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_ack_q <= 1'b0;
      uc_ack_q <= 1'b0;
      ext_rdata_q <= 8'h00;
      uc_rdata_q <= 8'h00;
    end else begin
      ext_ack_q <= ans_now && owner_ext_q;
      uc_ack_q <= ans_now && !owner_ext_q;
      if (ans_now && owner_ext_q) begin
        ext_rdata_q <= ans_data;
      end
      if (ans_now && !owner_ext_q) begin
        uc_rdata_q <= ans_data;
      end
    end
  end

  // ***********************************************
  // global registers
  // ***********************************************

  assign glb_wr = (st_q == pmrar_pkg::ST_DEC) && acc_q.we &&
                  (region == pmrar_pkg::RG_GLOBAL);

  // read mux; undefined global bytes read zero
  always_comb begin
    case (off[3:0])
      pmrar_pkg::GR_PAGE: glb_rdata = {6'h00, page_q};
      pmrar_pkg::GR_ROUTE0: glb_rdata = route_q[7:0];
      pmrar_pkg::GR_ROUTE1: glb_rdata = route_q[15:8];
      pmrar_pkg::GR_STAT0: glb_rdata = stat_q[7:0];
      pmrar_pkg::GR_STAT1: glb_rdata = stat_q[15:8];
      pmrar_pkg::GR_ACTION: glb_rdata = action_q;
      pmrar_pkg::GR_STATE: glb_rdata = {7'h00, uc_run};
      default: glb_rdata = 8'h00;
    endcase
  end

  // page select (low two bits only) and routing bytes are plain read/write
  // [RQ10] route bit set sends a source to the pin
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      page_q <= pmrar_pkg::PAGE_RST;
      route_q <= pmrar_pkg::ROUTE_RST;
    end else if (glb_wr) begin
      case (off[3:0])
        pmrar_pkg::GR_PAGE: page_q <= acc_q.wdata[1:0];
        pmrar_pkg::GR_ROUTE0: route_q[7:0] <= acc_q.wdata;
        pmrar_pkg::GR_ROUTE1: route_q[15:8] <= acc_q.wdata;
        default: begin
          page_q <= page_q;
        end
      endcase
    end
  end

  // [RQ23] write one fires the action strobe
  // written byte stays readable afterwards
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      action_q <= pmrar_pkg::ACTION_RST;
      action_pulse_q <= 1'b0;
    end else begin
      action_pulse_q <= glb_wr && (off[3:0] == pmrar_pkg::GR_ACTION) &&
                        acc_q.wdata[0];
      if (glb_wr && off[3:0] == pmrar_pkg::GR_ACTION) begin
        action_q <= acc_q.wdata;
      end
    end
  end

  // ***********************************************
  // interrupt status and routing
  // ***********************************************

  // sources beyond N_IRQ read as zero
  always_comb begin
    ev_wide = 16'h0000;
    ev_wide[N_IRQ-1:0] = irq_event;
  end

  // [RQ22] ones in a status write clear bits
  always_comb begin
    stat_clr = 16'h0000;
    if (glb_wr && off[3:0] == pmrar_pkg::GR_STAT0) begin
      stat_clr[7:0] = acc_q.wdata;
    end
    if (glb_wr && off[3:0] == pmrar_pkg::GR_STAT1) begin
      stat_clr[15:8] = acc_q.wdata;
    end
    // a new event in the clear cycle survives
    stat_d = (stat_q & ~stat_clr) | ev_wide;
  end

  // sticky status bits
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stat_q <= pmrar_pkg::STAT_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // [RQ9] pin carries pin-routed sources
  // [RQ10] the rest go to the micro
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_ext_q <= 1'b0;
      irq_uc_q <= 1'b0;
    end else begin
      irq_ext_q <= |(stat_q & route_q);
      irq_uc_q <= |(stat_q & ~route_q);
    end
  end

endmodule // pmrar_router

// ---- tb/pmrar_router_sva.sv ----
`timescale 1ns/1ps
// ***************************************
// router port checker
// ***************************************
module pmrar_router_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // masters
  input wire logic ext_req,
  input wire logic [7:0] ext_addr,
  input wire logic ext_ack_q,
  input wire logic uc_run,
  input wire logic uc_ack_q,
  // module port and strobe
  input wire pmrar_pkg::pmrar_mod_req_t mod_req_q,
  input wire logic mod_ack,
  input wire logic action_pulse_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // module request waiting, and answered
  sequence s_mod_wait;
    mod_req_q.req && !mod_ack;
  endsequence
  sequence s_mod_done;
    mod_req_q.req && mod_ack;
  endsequence
  a_ext_ack_pulse: assert property (ext_ack_q |=> !ext_ack_q)
    else $error("ext ack wider than one cycle");
  a_uc_ack_pulse: assert property (uc_ack_q |=> !uc_ack_q)
    else $error("uc ack wider than one cycle");
  a_no_dual_ack: assert property (!(ext_ack_q && uc_ack_q))
    else $error("both masters answered together");
  a_mod_hold_req: assert property (s_mod_wait |=>
    mod_req_q.req && $stable(mod_req_q))
    else $error("module request changed before answer");
  a_mod_done_ack: assert property (s_mod_done |=>
    !mod_req_q.req && (ext_ack_q || uc_ack_q))
    else $error("module answer not passed to master");
  a_mod_region_ok: assert property (mod_req_q.req |->
    mod_req_q.region != pmrar_pkg::RG_NONE &&
    mod_req_q.region != pmrar_pkg::RG_GLOBAL)
    else $error("module request with no module");
  a_global_fast: assert property (ext_req && !ext_ack_q &&
    ext_addr < 8'h10 |-> ##[1:16] ext_ack_q)
    else $error("global access not answered");
  // micro off for eight cycles gives no micro answer
  a_uc_off_idle: assert property (!uc_run [*8] |-> !uc_ack_q)
    else $error("micro answered while off");
  a_action_once: assert property (action_pulse_q |=>
    !action_pulse_q)
    else $error("action pulse wider than one cycle");
endmodule // pmrar_router_sva

bind pmrar_router pmrar_router_sva u_sva (
  .clk_sys(clk_sys),
  .rst(rst),
  .ext_req(ext_req),
  .ext_addr(ext_addr),
  .ext_ack_q(ext_ack_q),
  .uc_run(uc_run),
  .uc_ack_q(uc_ack_q),
  .mod_req_q(mod_req_q),
  .mod_ack(mod_ack),
  .action_pulse_q(action_pulse_q)
);

// ---- tb/pmrar_mod_model.sv ----
`timescale 1ns/1ps
// ***************************************
// downstream module responder
// ***************************************
module pmrar_mod_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // request and pacing
  input wire pmrar_pkg::pmrar_mod_req_t mod_req,
  input wire logic slow,
  // answer and bookkeeping
  output logic mod_ack,
  output logic [7:0] mod_rdata,
  output logic [3:0] last_region,
  output logic [7:0] last_off,
  output logic [7:0] hits
);
  logic [7:0] mem [0:4095];
  logic [2:0] wait_q;
  // byte store, one answer per request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mod_ack <= 1'b0;
      mod_rdata <= 8'h00;
      wait_q <= 3'h0;
      hits <= 8'h00;
      last_region <= 4'hF;
      last_off <= 8'h00;
    end else if (mod_req.req && !mod_ack &&
                 wait_q >= (slow ? 3'h4 : 3'h0)) begin
      mod_ack <= 1'b1;
      wait_q <= 3'h0;
      hits <= hits + 8'h01;
      last_region <= mod_req.region;
      last_off <= mod_req.off;
      mod_rdata <= mem[{mod_req.region, mod_req.off}];
      if (mod_req.we) mem[{mod_req.region, mod_req.off}] <= mod_req.wdata;
    end else begin
      mod_ack <= 1'b0;
      mod_rdata <= ~mod_rdata; // between answers rdata toggles, so the old value returns every other cycle
      wait_q <= (mod_req.req && !mod_ack) ? wait_q + 3'h1 : 3'h0;
    end
  end
endmodule // pmrar_mod_model

// ---- tb/pmic_register_access_router_bench.sv ----
`timescale 1ns/1ps
module pmic_register_access_router_bench;
  // ***************************************
  // signals
  // ***************************************
  logic clk_sys, rst, ext_req, ext_we, uc_run, uc_req, uc_we, slow;
  logic [7:0] ext_addr, ext_wdata, uc_wdata, ext_rdata_q, uc_rdata_q;
  logic [15:0] uc_addr, irq_event;
  logic ext_ack_q, uc_ack_q, mod_ack, irq_ext_q, irq_uc_q, action_pulse_q;
  logic [7:0] mod_rdata, last_off, hits, q0, q1, h;
  logic [3:0] last_region;
  logic [1:0] page_q;
  pmrar_pkg::pmrar_mod_req_t mod_req_q;
  int err_total, num_checks, pulses;
  time t_ack [2];
  logic [27:0] rtab [13] = '{28'hA010100, 28'hA03F21F, 28'hA040300,
    28'hA07F41F, 28'hA080500, 28'hA09F60F, 28'hA0A0700, 28'hA0C0800,
    28'hA0FF83F, 28'hA100900, 28'hA1EF9EF, 28'hA200A00, 28'hA2EFAEF};
  logic [15:0] xtab [8] = '{16'hA0B0, 16'hA0BF, 16'hA1F0, 16'hA2FF,
    16'hA300, 16'hA3FF, 16'h9FFF, 16'hA400};

  pmrar_router DUT (.clk_sys(clk_sys), .rst(rst), .ext_req(ext_req),
    .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_ack_q(ext_ack_q), .ext_rdata_q(ext_rdata_q), .uc_run(uc_run),
    .uc_req(uc_req), .uc_we(uc_we), .uc_addr(uc_addr),
    .uc_wdata(uc_wdata), .uc_ack_q(uc_ack_q), .uc_rdata_q(uc_rdata_q),
    .mod_req_q(mod_req_q), .mod_ack(mod_ack), .mod_rdata(mod_rdata),
    .irq_event(irq_event), .irq_ext_q(irq_ext_q), .irq_uc_q(irq_uc_q),
    .action_pulse_q(action_pulse_q), .page_q(page_q));
  pmrar_mod_model u_mod (.clk_sys(clk_sys), .rst(rst),
    .mod_req(mod_req_q), .slow(slow), .mod_ack(mod_ack),
    .mod_rdata(mod_rdata), .last_region(last_region),
    .last_off(last_off), .hits(hits));

  // ***************************************
  // clock, watchdog, pulse counter
  // ***************************************
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    wrap_up;
  end
  // counts action strobes where settled
  always @(negedge clk_sys) if (action_pulse_q === 1'b1) pulses++;

  // ***************************************
  // shared tasks
  // ***************************************
  task automatic chk8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one byte access; m=1 micro, m=0 external
  task automatic acc(input bit m, input logic we, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    if (m) begin
      uc_req <= 1'b1;
      uc_we <= we;
      uc_addr <= a;
      uc_wdata <= d;
    end else begin
      ext_req <= 1'b1;
      ext_we <= we;
      ext_addr <= a[7:0];
      ext_wdata <= d;
    end
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while ((m ? uc_ack_q : ext_ack_q) !== 1'b1 && n < 40);
    chk8("ack", 8'h01, {7'h00, m ? uc_ack_q : ext_ack_q});
    q = m ? uc_rdata_q : ext_rdata_q;
    t_ack[m] = $time;
    @(posedge clk_sys);
    if (m) uc_req <= 1'b0;
    else ext_req <= 1'b0;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ***************************************
  // scenarios
  // ***************************************
  task t_reset;
    @(negedge clk_sys);
    chk8("outputs", 8'h00, {3'h0, page_q, irq_ext_q, irq_uc_q,
      action_pulse_q});
    acc(0, 1'b0, 16'h0001, 8'h00, q0);
    chk8("route low", 8'h00, q0);
    $display("test reset done");
  endtask
  task t_regions;
    for (int i = 0; i < 13; i++) begin
      h = hits;
      acc(1, 1'b1, rtab[i][27:12], rtab[i][7:0] ^ 8'h5A, q0);
      chk8("region", {4'h0, rtab[i][11:8]}, {4'h0, last_region});
      chk8("offset", rtab[i][7:0], last_off);
      chk8("hits", h + 8'h01, hits);
      acc(1, 1'b0, rtab[i][27:12], 8'h00, q0);
      chk8("readback", rtab[i][7:0] ^ 8'h5A, q0);
    end
    $display("test regions done");
  endtask
  task t_reserved;
    for (int i = 0; i < 8; i++) begin
      h = hits;
      acc(1, 1'b1, xtab[i], 8'hA5, q0);
      acc(1, 1'b0, xtab[i], 8'h00, q0);
      chk8("reserved read", 8'h00, q0);
      chk8("reserved hits", h, hits);
    end
    $display("test reserved done");
  endtask
  task t_pages;
    for (int p = 1; p < 4; p++) begin
      acc(0, 1'b1, 16'h0000, p[7:0], q0);
      @(negedge clk_sys);
      chk8("page", p[7:0], {6'h00, page_q});
      h = hits;
      acc(0, 1'b1, 16'h0020, 8'hC0 | p[7:0], q0);
      if (p < 3) begin
        chk8("page region", 8'h08 + p[7:0], {4'h0, last_region});
        chk8("page offset", 8'h20, last_off);
        acc(1, 1'b0, 16'hA020 + {p[7:0], 8'h00}, 8'h00, q1);
        chk8("two views", 8'hC0 | p[7:0], q1);
      end else begin
        acc(0, 1'b0, 16'h0020, 8'h00, q1);
        chk8("page 3 read", 8'h00, q1);
        chk8("page 3 hits", h, hits);
      end
      acc(0, 1'b0, 16'h0000, 8'h00, q0);
      chk8("global page", p[7:0], q0);
    end
    acc(0, 1'b1, 16'h0000, 8'h00, q0);
    $display("test pages done");
  endtask
  task t_arb;
    slow <= 1'b1;
    fork
      acc(0, 1'b1, 16'h00C1, 8'h11, q0);
      acc(1, 1'b1, 16'hA0C2, 8'h22, q1);
    join
    chk8("ext first", 8'h01, {7'h00, t_ack[0] < t_ack[1]});
    acc(0, 1'b0, 16'h00C2, 8'h00, q0);
    chk8("uc write kept", 8'h22, q0);
    acc(1, 1'b0, 16'hA0C1, 8'h00, q1);
    chk8("ext write kept", 8'h11, q1);
    slow <= 1'b0;
    $display("test arbitration done");
  endtask
  task t_uc_off;
    @(posedge clk_sys);
    uc_run <= 1'b0;
    fork
      acc(1, 1'b0, 16'hA006, 8'h00, q1);
      begin
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        chk8("uc stalled", 8'h00, {7'h00, uc_ack_q});
        acc(0, 1'b0, 16'h0006, 8'h00, q0);
        chk8("run off", 8'h00, q0);
        uc_run <= 1'b1;
      end
    join
    chk8("run on", 8'h01, q1);
    $display("test micro off done");
  endtask
  task t_irq;
    // software side: route byte is read, modified and written back
    acc(1, 1'b0, 16'hA001, 8'h00, q0);
    acc(1, 1'b1, 16'hA001, q0 | 8'h01, q0);
    @(posedge clk_sys);
    irq_event <= 16'h0003;
    @(posedge clk_sys);
    irq_event <= 16'h0000;
    repeat (3) @(negedge clk_sys);
    chk8("irq both", 8'h03, {6'h00, irq_ext_q, irq_uc_q});
    acc(0, 1'b0, 16'h0003, 8'h00, q0);
    chk8("status", 8'h03, q0);
    acc(0, 1'b1, 16'h0003, 8'h01, q0);
    repeat (2) @(negedge clk_sys);
    chk8("irq pin clear", 8'h01, {6'h00, irq_ext_q, irq_uc_q});
    acc(1, 1'b1, 16'hA003, 8'h02, q0);
    repeat (2) @(negedge clk_sys);
    chk8("irq all clear", 8'h00, {6'h00, irq_ext_q, irq_uc_q});
    $display("test interrupts done");
  endtask
  task t_action;
    pulses = 0;
    acc(1, 1'b1, 16'hA005, 8'h01, q0);
    repeat (3) @(negedge clk_sys);
    chk8("one pulse", 8'h01, pulses[7:0]);
    acc(0, 1'b0, 16'h0005, 8'h00, q0);
    chk8("action readable", 8'h01, q0);
    acc(0, 1'b1, 16'h0005, 8'h00, q0);
    repeat (3) @(negedge clk_sys);
    chk8("no pulse on zero", 8'h01, pulses[7:0]);
    $display("test action done");
  endtask

  // ***************************************
  // main sequence
  // ***************************************
  initial begin
    err_total = 0;
    num_checks = 0;
    pulses = 0;
    rst = 1'b1;
    {ext_req, ext_we, uc_req, uc_we, slow} = 5'h00;
    uc_run = 1'b1;
    {ext_addr, ext_wdata, uc_wdata} = 24'h000000;
    uc_addr = 16'h0000;
    irq_event = 16'h0000;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_regions;
    t_reserved;
    t_pages;
    t_arb;
    t_uc_off;
    t_irq;
    t_action;
    wrap_up;
  end
endmodule // pmic_register_access_router_bench
